/* oag_core.sv */
`timescale 1ns/1ps

// Operation
// - Waited external byte costs two extra cycles
// - Waited external stack adds four cycles
// - Registers 26 to 31 are pointers
// - Every mode except I/O reaches the whole data space
// - Direct mode uses full 16-bit address
// - Y or Z plus 6-bit displacement
// - Single register operand from destination
// - Two operands, result into destination
// - I/O address from six-bit field
// - Plain indirect uses pointer unchanged
// - Pre-decrement then use new pointer
// - Use pointer then post-increment
// - Z word select, bit 0 byte
// - Pointer jump or call loads Z
// - Relative target is PC plus k plus one
// - Internal SRAM access takes two cycles
// - Register ALU operation in one cycle
// - Core runs on undivided system clock
// - I/O data address is I/O plus 0x20
// - Bit instructions only on low 32 I/O
// - Bit set/clear rewrites whole register
// - Decode registers, I/O, internal, external
// - Plain external access adds one cycle
module oag_core #(
    parameter int unsigned NUM_REGS = 32,
    parameter int unsigned PC_W = 12
) (
    input wire logic CLOCK_IN,
    input wire logic SRST_IN,
    input wire logic START_IN,
    input wire oag_pkg::oag_mode_t MODE_IN,
    input wire oag_pkg::oag_ptr_t PTR_SEL_IN,
    input wire logic [5:0] DISP_IN,
    input wire logic [15:0] DIRECT_ADDR_IN,
    input wire logic [5:0] IO_ADDR_IN,
    input wire logic WAIT_STATE_IN,
    input wire logic [4:0] DST_SEL_IN,
    input wire logic [4:0] SRC_SEL_IN,
    input wire logic RESULT_WE_IN,
    input wire logic [7:0] RESULT_IN,
    input wire logic LOAD_WE_IN,
    input wire logic [4:0] LOAD_SEL_IN,
    input wire logic [7:0] LOAD_DATA_IN,
    input wire logic BIT_GO_IN,
    input wire oag_pkg::oag_bit_op_t BIT_OP_IN,
    input wire logic [2:0] BIT_SEL_IN,
    input wire logic [7:0] IO_RDATA_IN,
    input wire logic PGM_GO_IN,
    input wire oag_pkg::oag_pgm_op_t PGM_OP_IN,
    input wire logic [PC_W-1:0] PC_IN,
    input wire logic [PC_W-1:0] OFFSET_IN,
    input wire logic [15:0] SP_IN,
    output logic [7:0] DST_DATA_OUT,
    output logic [7:0] SRC_DATA_OUT,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic [15:0] DATA_ADDR_OUT,
    output oag_pkg::oag_region_t REGION_OUT,
    output logic [2:0] ACCESS_CYCLES_OUT,
    output logic IO_WE_OUT,
    output logic [5:0] IO_WADDR_OUT,
    output logic [7:0] IO_WDATA_OUT,
    output logic SKIP_OUT,
    output logic BIT_REJECT_OUT,
    output logic PC_LOAD_OUT,
    output logic [PC_W-1:0] PC_NEXT_OUT,
    output logic CONST_VALID_OUT,
    output logic [14:0] PGM_WORD_ADDR_OUT,
    output logic PGM_HIGH_BYTE_OUT,
    output logic [2:0] STACK_EXTRA_OUT
);

    typedef enum logic {
        OAG_S_IDLE,
        OAG_S_ACCESS
    } oag_state_t;

    // ****************************************
    // Working registers and pointers
    // ****************************************
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] regs_d [NUM_REGS];
    logic [4:0] ptr_lo;
    logic [4:0] ptr_hi;
    logic [15:0] cur_ptr;
    logic [15:0] z_ptr;
    logic [15:0] ind_addr;
    logic [15:0] ptr_next;
    logic ptr_we;
    logic take;

    always_comb begin
        case (PTR_SEL_IN)
            oag_pkg::OAG_PTR_X: ptr_lo = oag_pkg::PTR_X_LOW;
            oag_pkg::OAG_PTR_Y: ptr_lo = oag_pkg::PTR_Y_LOW;
            default: ptr_lo = oag_pkg::PTR_Z_LOW;
        endcase
        // Displacement has no X form; X falls back to Y
        if (MODE_IN == oag_pkg::OAG_MODE_DISP && PTR_SEL_IN == oag_pkg::OAG_PTR_X) begin
            ptr_lo = oag_pkg::PTR_Y_LOW;
        end
        ptr_hi = ptr_lo + 5'h01;
        cur_ptr = {regs_q[ptr_hi], regs_q[ptr_lo]};
        z_ptr = {regs_q[oag_pkg::PTR_Z_LOW + 5'h01], regs_q[oag_pkg::PTR_Z_LOW]};
    end

    oag_ptr_unit #(
        .PTR_W(16),
        .DISP_W(6)
    ) u_ptr (
        .ptr_in(cur_ptr),
        .mode_in(MODE_IN),
        .disp_in(DISP_IN),
        .addr_out(ind_addr),
        .ptr_next_out(ptr_next),
        .ptr_we_out(ptr_we)
    );

    assign DST_DATA_OUT = regs_q[DST_SEL_IN];
    assign SRC_DATA_OUT = regs_q[SRC_SEL_IN];

    always_comb begin
        regs_d = regs_q;
        if (LOAD_WE_IN) begin
            regs_d[LOAD_SEL_IN] = LOAD_DATA_IN;
        end
        // ALU result lands on the rising edge that closes the cycle its operands were read in
        if (RESULT_WE_IN) begin
            regs_d[DST_SEL_IN] = RESULT_IN;
        end
        if (take && ptr_we) begin
            regs_d[ptr_lo] = ptr_next[7:0];
            regs_d[ptr_hi] = ptr_next[15:8];
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            regs_q <= '{default: oag_pkg::REG_RESET};
        end else begin
            regs_q <= regs_d;
        end
    end

    // ****************************************
    // Operand address and access timing
    // ****************************************
    oag_state_t state_q;
    oag_state_t state_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    oag_pkg::oag_region_t rgn_q;
    oag_pkg::oag_region_t rgn_d;
    logic [15:0] op_addr;
    oag_pkg::oag_region_t op_rgn;
    logic [2:0] op_cycles;

    assign take = START_IN && (state_q == OAG_S_IDLE);

    always_comb begin
        case (MODE_IN)
            oag_pkg::OAG_MODE_DIRECT: op_addr = DIRECT_ADDR_IN;
            oag_pkg::OAG_MODE_IO: op_addr = {10'h000, IO_ADDR_IN} + oag_pkg::IO_DATA_OFFSET;
            default: op_addr = ind_addr;
        endcase
        if (op_addr < oag_pkg::REG_SPACE_END) begin
            op_rgn = oag_pkg::OAG_RGN_REG;
        end else if (op_addr < oag_pkg::IO_SPACE_END) begin
            op_rgn = oag_pkg::OAG_RGN_IO;
        end else if (op_addr < oag_pkg::INT_SRAM_END) begin
            op_rgn = oag_pkg::OAG_RGN_INT;
        end else begin
            op_rgn = oag_pkg::OAG_RGN_EXT;
        end
        case (op_rgn)
            oag_pkg::OAG_RGN_INT: op_cycles = oag_pkg::CYC_INT_SRAM;
            oag_pkg::OAG_RGN_EXT: begin
                if (WAIT_STATE_IN) begin
                    op_cycles = oag_pkg::CYC_INT_SRAM + oag_pkg::CYC_EXT_WAIT_EXTRA;
                end else begin
                    op_cycles = oag_pkg::CYC_INT_SRAM + oag_pkg::CYC_EXT_EXTRA;
                end
            end
            default: op_cycles = oag_pkg::CYC_ONE;
        endcase
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        rgn_d = rgn_q;
        case (state_q)
            OAG_S_IDLE: begin
                if (START_IN) begin
                    addr_d = op_addr;
                    rgn_d = op_rgn;
                    cnt_d = op_cycles;
                    state_d = OAG_S_ACCESS;
                end
            end
            OAG_S_ACCESS: begin
                if (cnt_q == oag_pkg::CYC_ONE) begin
                    state_d = OAG_S_IDLE;
                end else begin
                    cnt_d = cnt_q - oag_pkg::CYC_ONE;
                end
            end
            default: begin
                state_d = OAG_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            state_q <= OAG_S_IDLE;
            cnt_q <= oag_pkg::CYC_ONE;
            addr_q <= oag_pkg::ADDR_RESET;
            rgn_q <= oag_pkg::OAG_RGN_REG;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            rgn_q <= rgn_d;
        end
    end

    assign BUSY_OUT = (state_q == OAG_S_ACCESS);
    assign DONE_OUT = (state_q == OAG_S_ACCESS) && (cnt_q == oag_pkg::CYC_ONE);
    assign DATA_ADDR_OUT = addr_q;
    assign REGION_OUT = rgn_q;
    assign ACCESS_CYCLES_OUT = cnt_q;

    // ****************************************
    // I/O bit access
    // ****************************************
    logic io_we_q;
    logic io_we_d;
    logic [5:0] io_waddr_q;
    logic [5:0] io_waddr_d;
    logic [7:0] io_wdata_q;
    logic [7:0] io_wdata_d;
    logic skip_q;
    logic skip_d;
    logic reject_q;
    logic reject_d;
    logic [7:0] bit_mask;

    always_comb begin
        bit_mask = 8'h01 << BIT_SEL_IN;
        io_we_d = 1'b0;
        io_waddr_d = io_waddr_q;
        io_wdata_d = io_wdata_q;
        skip_d = 1'b0;
        reject_d = 1'b0;
        if (BIT_GO_IN && BIT_OP_IN != oag_pkg::OAG_BIT_NONE) begin
            if (IO_ADDR_IN >= oag_pkg::BIT_IO_LIMIT) begin
                reject_d = 1'b1;
            end else begin
                io_waddr_d = IO_ADDR_IN;
                // Whole byte goes back, so set flags read as one are written back as one
                case (BIT_OP_IN)
                    oag_pkg::OAG_BIT_IO_BIT_SET: begin
                        io_we_d = 1'b1;
                        io_wdata_d = IO_RDATA_IN | bit_mask;
                    end
                    oag_pkg::OAG_BIT_IO_BIT_CLEAR: begin
                        io_we_d = 1'b1;
                        io_wdata_d = IO_RDATA_IN & ~bit_mask;
                    end
                    oag_pkg::OAG_BIT_SKIP_IF_IO_BIT_ONE: skip_d = |(IO_RDATA_IN & bit_mask);
                    oag_pkg::OAG_BIT_SKIP_IF_IO_BIT_ZERO: skip_d = ~|(IO_RDATA_IN & bit_mask);
                    default: skip_d = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            io_we_q <= 1'b0;
            io_waddr_q <= 6'h00;
            io_wdata_q <= 8'h00;
            skip_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            io_we_q <= io_we_d;
            io_waddr_q <= io_waddr_d;
            io_wdata_q <= io_wdata_d;
            skip_q <= skip_d;
            reject_q <= reject_d;
        end
    end

    assign IO_WE_OUT = io_we_q;
    assign IO_WADDR_OUT = io_waddr_q;
    assign IO_WDATA_OUT = io_wdata_q;
    assign SKIP_OUT = skip_q;
    assign BIT_REJECT_OUT = reject_q;

    // ****************************************
    // Program space addressing
    // ****************************************
    logic pc_load_q;
    logic pc_load_d;
    logic [PC_W-1:0] pc_next_q;
    logic [PC_W-1:0] pc_next_d;
    logic const_q;
    logic const_d;
    logic [14:0] word_q;
    logic [14:0] word_d;
    logic high_q;
    logic high_d;
    logic [2:0] stack_q;
    logic [2:0] stack_d;

    always_comb begin
        pc_load_d = 1'b0;
        pc_next_d = pc_next_q;
        const_d = 1'b0;
        word_d = word_q;
        high_d = high_q;
        if (PGM_GO_IN) begin
            case (PGM_OP_IN)
                oag_pkg::OAG_PGM_PROGRAM_CONSTANT_LOAD: begin
                    const_d = 1'b1;
                    word_d = z_ptr[15:1];
                    high_d = z_ptr[0];
                end
                oag_pkg::OAG_PGM_POINTER_JUMP, oag_pkg::OAG_PGM_POINTER_CALL: begin
                    pc_load_d = 1'b1;
                    pc_next_d = z_ptr[PC_W-1:0];
                end
                oag_pkg::OAG_PGM_OFFSET_JUMP, oag_pkg::OAG_PGM_OFFSET_CALL: begin
                    // Wraps modulo program size, so any target is reachable
                    pc_load_d = 1'b1;
                    pc_next_d = PC_IN + OFFSET_IN + oag_pkg::PC_STEP;
                end
                default: pc_load_d = 1'b0;
            endcase
        end
        if (SP_IN < oag_pkg::INT_SRAM_END) begin
            stack_d = 3'h0;
        end else if (WAIT_STATE_IN) begin
            stack_d = oag_pkg::STACK_EXTRA_WAIT;
        end else begin
            stack_d = oag_pkg::STACK_EXTRA_PLAIN;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            pc_load_q <= 1'b0;
            pc_next_q <= oag_pkg::PC_RESET;
            const_q <= 1'b0;
            word_q <= 15'h0000;
            high_q <= 1'b0;
            stack_q <= 3'h0;
        end else begin
            pc_load_q <= pc_load_d;
            pc_next_q <= pc_next_d;
            const_q <= const_d;
            word_q <= word_d;
            high_q <= high_d;
            stack_q <= stack_d;
        end
    end

    assign PC_LOAD_OUT = pc_load_q;
    assign PC_NEXT_OUT = pc_next_q;
    assign CONST_VALID_OUT = const_q;
    assign PGM_WORD_ADDR_OUT = word_q;
    assign PGM_HIGH_BYTE_OUT = high_q;
    assign STACK_EXTRA_OUT = stack_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);

    io_map_a: assert property (
        take && MODE_IN == oag_pkg::OAG_MODE_IO
        |=> DATA_ADDR_OUT == 16'($past(IO_ADDR_IN)) + 16'h0020
    ) else $error("I/O data address not offset by 0x20");

    int_cycles_a: assert property (
        take && op_rgn == oag_pkg::OAG_RGN_INT |=> !DONE_OUT ##1 DONE_OUT
    ) else $error("Internal SRAM access not two cycles");

    ext_cycles_a: assert property (
        take && op_rgn == oag_pkg::OAG_RGN_EXT && !WAIT_STATE_IN |=> !DONE_OUT [*2] ##1 DONE_OUT
    ) else $error("External access not three cycles");

    wait_cycles_a: assert property (
        take && op_rgn == oag_pkg::OAG_RGN_EXT && WAIT_STATE_IN |=> !DONE_OUT [*3] ##1 DONE_OUT
    ) else $error("Wait-stated access not four cycles");

    stack_wait_a: assert property (
        SP_IN >= 16'h0260 && WAIT_STATE_IN |=> STACK_EXTRA_OUT == 3'h4
    ) else $error("Wait-stated stack extra not four");

    post_inc_a: assert property (
        take && MODE_IN == oag_pkg::OAG_MODE_POSTINC
        |=> DATA_ADDR_OUT == $past(cur_ptr) && {regs_q[$past(ptr_hi)], regs_q[$past(ptr_lo)]}
            == $past(cur_ptr) + 16'h0001
    ) else $error("Post-increment address or update wrong");

    pre_dec_a: assert property (
        take && MODE_IN == oag_pkg::OAG_MODE_PREDEC
        |=> DATA_ADDR_OUT == $past(cur_ptr) - 16'h0001
    ) else $error("Pre-decrement address wrong");

    disp_add_a: assert property (
        take && MODE_IN == oag_pkg::OAG_MODE_DISP |=> DATA_ADDR_OUT == $past(cur_ptr) + 16'($past(DISP_IN))
    ) else $error("Displaced address wrong");

    bit_range_a: assert property (
        IO_WE_OUT |-> IO_WADDR_OUT < 6'h20 && IO_WADDR_OUT == $past(IO_ADDR_IN)
    ) else $error("Bit write above low I/O range");

    rel_target_a: assert property (
        PGM_GO_IN && PGM_OP_IN == oag_pkg::OAG_PGM_OFFSET_CALL
        |=> PC_LOAD_OUT && PC_NEXT_OUT == $past(PC_IN) + $past(OFFSET_IN) + 12'h001
    ) else $error("Relative target wrong");

    const_byte_a: assert property (
        PGM_GO_IN && PGM_OP_IN == oag_pkg::OAG_PGM_PROGRAM_CONSTANT_LOAD
        |=> CONST_VALID_OUT && {PGM_WORD_ADDR_OUT, PGM_HIGH_BYTE_OUT} == $past(z_ptr)
    ) else $error("Constant load byte address wrong");

endmodule

/* oag_pkg.sv */
package oag_pkg;

    // ****************************************
    // Data space map
    // ****************************************
    localparam logic [15:0] REG_SPACE_END = 16'h0020;
    localparam logic [15:0] IO_SPACE_END = 16'h0060;
    localparam logic [15:0] INT_SRAM_END = 16'h0260;
    localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
    localparam logic [5:0] BIT_IO_LIMIT = 6'h20;

    // ****************************************
    // Pointer register positions
    // ****************************************
    localparam logic [4:0] PTR_X_LOW = 5'h1A;
    localparam logic [4:0] PTR_Y_LOW = 5'h1C;
    localparam logic [4:0] PTR_Z_LOW = 5'h1E;

    // ****************************************
    // Access cycle counts
    // ****************************************
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_INT_SRAM = 3'h2;
    localparam logic [2:0] CYC_EXT_EXTRA = 3'h1;
    localparam logic [2:0] CYC_EXT_WAIT_EXTRA = 3'h2;
    localparam logic [2:0] STACK_EXTRA_PLAIN = 3'h2;
    localparam logic [2:0] STACK_EXTRA_WAIT = 3'h4;

    // ****************************************
    // Reset values and PC step
    // ****************************************
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [11:0] PC_STEP = 12'h001;

    typedef enum logic [2:0] {
        OAG_MODE_DIRECT,
        OAG_MODE_IO,
        OAG_MODE_IND,
        OAG_MODE_DISP,
        OAG_MODE_PREDEC,
        OAG_MODE_POSTINC
    } oag_mode_t;

    typedef enum logic [1:0] {
        OAG_PTR_X,
        OAG_PTR_Y,
        OAG_PTR_Z
    } oag_ptr_t;

    typedef enum logic [1:0] {
        OAG_RGN_REG,
        OAG_RGN_IO,
        OAG_RGN_INT,
        OAG_RGN_EXT
    } oag_region_t;

    typedef enum logic [2:0] {
        OAG_BIT_NONE,
        OAG_BIT_IO_BIT_SET,
        OAG_BIT_IO_BIT_CLEAR,
        OAG_BIT_SKIP_IF_IO_BIT_ONE,
        OAG_BIT_SKIP_IF_IO_BIT_ZERO
    } oag_bit_op_t;

    typedef enum logic [2:0] {
        OAG_PGM_NONE,
        OAG_PGM_PROGRAM_CONSTANT_LOAD,
        OAG_PGM_POINTER_JUMP,
        OAG_PGM_POINTER_CALL,
        OAG_PGM_OFFSET_JUMP,
        OAG_PGM_OFFSET_CALL
    } oag_pgm_op_t;

endpackage

/* oag_ptr_unit.sv */
`timescale 1ns/1ps

module oag_ptr_unit #(
    parameter int unsigned PTR_W = 16,
    parameter int unsigned DISP_W = 6
) (
    input wire logic [PTR_W-1:0] ptr_in,
    input wire oag_pkg::oag_mode_t mode_in,
    input wire logic [DISP_W-1:0] disp_in,
    output logic [PTR_W-1:0] addr_out,
    output logic [PTR_W-1:0] ptr_next_out,
    output logic ptr_we_out
);

    always_comb begin
        addr_out = ptr_in;
        ptr_next_out = ptr_in;
        ptr_we_out = 1'b0;
        case (mode_in)
            oag_pkg::OAG_MODE_IND: begin
                addr_out = ptr_in;
            end
            oag_pkg::OAG_MODE_DISP: begin
                addr_out = ptr_in + PTR_W'(disp_in);
            end
            oag_pkg::OAG_MODE_PREDEC: begin
                // Full-width step so a carry crosses the byte pair
                ptr_next_out = ptr_in - PTR_W'(1);
                addr_out = ptr_in - PTR_W'(1);
                ptr_we_out = 1'b1;
            end
            oag_pkg::OAG_MODE_POSTINC: begin
                ptr_next_out = ptr_in + PTR_W'(1);
                addr_out = ptr_in;
                ptr_we_out = 1'b1;
            end
            default: begin
                addr_out = ptr_in;
            end
        endcase
    end

endmodule

/* oag_io_model.sv */
`timescale 1ns/1ps

// ****************************************
// I/O register space behind the core
// ****************************************
module oag_io_model #(
    parameter logic [7:0] INIT = 8'h81
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [5:0] io_addr_in,
    input wire logic io_we_in,
    input wire logic [5:0] io_waddr_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out
);
    logic [7:0] mem_q [64];

    // Whole byte stored, so set flags written back land as ones
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= INIT;
            end
        end else if (io_we_in) begin
            mem_q[io_waddr_in] <= io_wdata_in;
        end
    end

    assign io_rdata_out = mem_q[io_addr_in];
endmodule

/* oag_core_tb_top.sv */
`timescale 1ns/1ps

module oag_core_tb_top;
    import oag_pkg::*;
    logic CLOCK_IN = 1'b0, SRST_IN = 1'b1, START_IN = 1'b0, WAIT_STATE_IN = 1'b0;
    logic RESULT_WE_IN = 1'b0, LOAD_WE_IN = 1'b0, BIT_GO_IN = 1'b0, PGM_GO_IN = 1'b0;
    oag_mode_t MODE_IN = OAG_MODE_DIRECT;
    oag_ptr_t PTR_SEL_IN = OAG_PTR_X;
    oag_bit_op_t BIT_OP_IN = OAG_BIT_NONE;
    oag_pgm_op_t PGM_OP_IN = OAG_PGM_NONE;
    logic [5:0] DISP_IN = 6'h00, IO_ADDR_IN = 6'h00;
    logic [15:0] DIRECT_ADDR_IN = 16'h0000, SP_IN = 16'h0000;
    logic [4:0] DST_SEL_IN = 5'h00, SRC_SEL_IN = 5'h00, LOAD_SEL_IN = 5'h00;
    logic [7:0] RESULT_IN = 8'h00, LOAD_DATA_IN = 8'h00, IO_RDATA_IN;
    logic [2:0] BIT_SEL_IN = 3'h0;
    logic [11:0] PC_IN = 12'h000, OFFSET_IN = 12'h000, PC_NEXT_OUT;
    logic [7:0] DST_DATA_OUT, SRC_DATA_OUT, IO_WDATA_OUT;
    logic BUSY_OUT, DONE_OUT, IO_WE_OUT, SKIP_OUT, BIT_REJECT_OUT, PC_LOAD_OUT;
    logic CONST_VALID_OUT, PGM_HIGH_BYTE_OUT;
    logic [15:0] DATA_ADDR_OUT;
    oag_region_t REGION_OUT;
    logic [2:0] ACCESS_CYCLES_OUT, STACK_EXTRA_OUT;
    logic [5:0] IO_WADDR_OUT;
    logic [14:0] PGM_WORD_ADDR_OUT;
    int fail_count = 0;
    int samples_checked = 0;

    always #50 CLOCK_IN = ~CLOCK_IN;

    oag_core uut (.CLOCK_IN, .SRST_IN, .START_IN, .MODE_IN, .PTR_SEL_IN, .DISP_IN,
        .DIRECT_ADDR_IN, .IO_ADDR_IN, .WAIT_STATE_IN, .DST_SEL_IN, .SRC_SEL_IN,
        .RESULT_WE_IN, .RESULT_IN, .LOAD_WE_IN, .LOAD_SEL_IN, .LOAD_DATA_IN, .BIT_GO_IN,
        .BIT_OP_IN, .BIT_SEL_IN, .IO_RDATA_IN, .PGM_GO_IN, .PGM_OP_IN, .PC_IN, .OFFSET_IN,
        .SP_IN, .DST_DATA_OUT, .SRC_DATA_OUT, .BUSY_OUT, .DONE_OUT, .DATA_ADDR_OUT,
        .REGION_OUT, .ACCESS_CYCLES_OUT, .IO_WE_OUT, .IO_WADDR_OUT, .IO_WDATA_OUT,
        .SKIP_OUT, .BIT_REJECT_OUT, .PC_LOAD_OUT, .PC_NEXT_OUT, .CONST_VALID_OUT,
        .PGM_WORD_ADDR_OUT, .PGM_HIGH_BYTE_OUT, .STACK_EXTRA_OUT);

    oag_io_model io_space (.clock_in(CLOCK_IN), .srst_in(SRST_IN), .io_addr_in(IO_ADDR_IN),
        .io_we_in(IO_WE_OUT), .io_waddr_in(IO_WADDR_OUT), .io_wdata_in(IO_WDATA_OUT),
        .io_rdata_out(IO_RDATA_IN));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Writes a register pair, low byte first
    task automatic ld16(input logic [4:0] lo, input logic [15:0] v);
        @(negedge CLOCK_IN);
        LOAD_WE_IN = 1'b1;
        LOAD_SEL_IN = lo;
        LOAD_DATA_IN = v[7:0];
        @(negedge CLOCK_IN);
        LOAD_SEL_IN = lo + 5'h01;
        LOAD_DATA_IN = v[15:8];
        @(negedge CLOCK_IN);
        LOAD_WE_IN = 1'b0;
    endtask

    task automatic rd16(input logic [4:0] lo, input logic [15:0] exp);
        @(negedge CLOCK_IN);
        DST_SEL_IN = lo;
        SRC_SEL_IN = lo + 5'h01;
        #1 chk("pair", exp, {SRC_DATA_OUT, DST_DATA_OUT});
    endtask

    task automatic dop(input oag_mode_t m, input oag_ptr_t p, input logic w,
        input logic [15:0] ea, input oag_region_t er, input logic [2:0] en);
        int n;
        @(negedge CLOCK_IN);
        MODE_IN = m;
        PTR_SEL_IN = p;
        WAIT_STATE_IN = w;
        START_IN = 1'b1;
        n = 0;
        do begin
            @(negedge CLOCK_IN);
            START_IN = 1'b0;
            n++;
            if (n == 1) chk("left", {13'h0001, en}, {12'h000, BUSY_OUT, ACCESS_CYCLES_OUT});
        end while (DONE_OUT !== 1'b1 && n < 8);
        if (DONE_OUT !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
        chk("address", ea, DATA_ADDR_OUT);
        chk("region", 16'(er), 16'(REGION_OUT));
        chk("cycles", 16'(en), 16'(n));
        @(negedge CLOCK_IN);
    endtask

    task automatic bop(input oag_bit_op_t op, input logic [5:0] a, input logic [2:0] b,
        input logic we, input logic [7:0] wd, input logic sk, input logic rj);
        @(negedge CLOCK_IN);
        BIT_GO_IN = 1'b1;
        BIT_OP_IN = op;
        IO_ADDR_IN = a;
        BIT_SEL_IN = b;
        @(negedge CLOCK_IN);
        BIT_GO_IN = 1'b0;
        chk("bit flags", {13'h0000, we, sk, rj}, {13'h0000, IO_WE_OUT, SKIP_OUT, BIT_REJECT_OUT});
        if (we) begin
            chk("io write", {2'h0, a, wd}, {2'h0, IO_WADDR_OUT, IO_WDATA_OUT});
        end
    endtask

    task automatic pop(input oag_pgm_op_t op, input logic [11:0] pc, input logic [11:0] k,
        input logic ld, input logic [11:0] epc);
        @(negedge CLOCK_IN);
        PGM_GO_IN = 1'b1;
        PGM_OP_IN = op;
        PC_IN = pc;
        OFFSET_IN = k;
        @(negedge CLOCK_IN);
        PGM_GO_IN = 1'b0;
        chk("pc load", {15'h0000, ld}, {15'h0000, PC_LOAD_OUT});
        if (ld) begin
            chk("pc next", {4'h0, epc}, {4'h0, PC_NEXT_OUT});
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_ptr;
        ld16(PTR_X_LOW, 16'h0100);
        dop(OAG_MODE_POSTINC, OAG_PTR_X, 1'b0, 16'h0100, OAG_RGN_INT, 3'h2);
        rd16(PTR_X_LOW, 16'h0101);
        ld16(PTR_Y_LOW, 16'h0300);
        dop(OAG_MODE_PREDEC, OAG_PTR_Y, 1'b0, 16'h02FF, OAG_RGN_EXT, 3'h3);
        rd16(PTR_Y_LOW, 16'h02FF);
        dop(OAG_MODE_IND, OAG_PTR_Y, 1'b1, 16'h02FF, OAG_RGN_EXT, 3'h4);
        rd16(PTR_Y_LOW, 16'h02FF);
        ld16(PTR_Z_LOW, 16'h00FF);
        dop(OAG_MODE_POSTINC, OAG_PTR_Z, 1'b0, 16'h00FF, OAG_RGN_INT, 3'h2);
        rd16(PTR_Z_LOW, 16'h0100);
        DISP_IN = 6'h3F;
        dop(OAG_MODE_DISP, OAG_PTR_Z, 1'b0, 16'h013F, OAG_RGN_INT, 3'h2);
    endtask

    task automatic t_direct;
        DIRECT_ADDR_IN = 16'h001F;
        dop(OAG_MODE_DIRECT, OAG_PTR_X, 1'b0, 16'h001F, OAG_RGN_REG, 3'h1);
        DIRECT_ADDR_IN = 16'h025F;
        dop(OAG_MODE_DIRECT, OAG_PTR_X, 1'b0, 16'h025F, OAG_RGN_INT, 3'h2);
        DIRECT_ADDR_IN = 16'hFFFF;
        dop(OAG_MODE_DIRECT, OAG_PTR_X, 1'b0, 16'hFFFF, OAG_RGN_EXT, 3'h3);
        IO_ADDR_IN = 6'h3F;
        dop(OAG_MODE_IO, OAG_PTR_X, 1'b0, 16'h005F, OAG_RGN_IO, 3'h1);
    endtask

    // Bench writes only mapped low I/O bytes, never reserved places
    task automatic t_bits;
        bop(OAG_BIT_IO_BIT_SET, 6'h18, 3'h3, 1'b1, 8'h89, 1'b0, 1'b0);
        bop(OAG_BIT_IO_BIT_CLEAR, 6'h18, 3'h0, 1'b1, 8'h88, 1'b0, 1'b0);
        bop(OAG_BIT_SKIP_IF_IO_BIT_ONE, 6'h18, 3'h3, 1'b0, 8'h00, 1'b1, 1'b0);
        bop(OAG_BIT_SKIP_IF_IO_BIT_ZERO, 6'h18, 3'h3, 1'b0, 8'h00, 1'b0, 1'b0);
        bop(OAG_BIT_SKIP_IF_IO_BIT_ZERO, 6'h1F, 3'h1, 1'b0, 8'h00, 1'b1, 1'b0);
        bop(OAG_BIT_IO_BIT_SET, 6'h21, 3'h0, 1'b0, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic t_pgm;
        pop(OAG_PGM_OFFSET_CALL, 12'h010, 12'hFFE, 1'b1, 12'h00F);
        pop(OAG_PGM_OFFSET_JUMP, 12'h000, 12'h7FF, 1'b1, 12'h800);
        pop(OAG_PGM_OFFSET_JUMP, 12'h900, 12'h800, 1'b1, 12'h101);
        ld16(PTR_Z_LOW, 16'h0A35);
        pop(OAG_PGM_POINTER_JUMP, 12'h000, 12'h000, 1'b1, 12'hA35);
        pop(OAG_PGM_POINTER_CALL, 12'h123, 12'h000, 1'b1, 12'hA35);
        pop(OAG_PGM_PROGRAM_CONSTANT_LOAD, 12'h000, 12'h000, 1'b0, 12'h000);
        chk("const", 16'h851A, {CONST_VALID_OUT, PGM_WORD_ADDR_OUT});
        chk("high byte", 16'h0001, {15'h0000, PGM_HIGH_BYTE_OUT});
        ld16(PTR_Z_LOW, 16'h0A34);
        pop(OAG_PGM_PROGRAM_CONSTANT_LOAD, 12'h000, 12'h000, 1'b0, 12'h000);
        chk("low byte", 16'h0000, {15'h0000, PGM_HIGH_BYTE_OUT});
    endtask

    task automatic t_alu;
        ld16(5'h03, 16'h3412);
        @(negedge CLOCK_IN);
        DST_SEL_IN = 5'h03;
        SRC_SEL_IN = 5'h04;
        #1 chk("operands", 16'h3412, {SRC_DATA_OUT, DST_DATA_OUT});
        @(negedge CLOCK_IN);
        RESULT_WE_IN = 1'b1;
        RESULT_IN = 8'h46;
        @(negedge CLOCK_IN);
        RESULT_WE_IN = 1'b0;
        chk("result", 16'h3446, {SRC_DATA_OUT, DST_DATA_OUT});
    endtask

    task automatic t_stack(input logic [15:0] sp, input logic w, input logic [2:0] e);
        @(negedge CLOCK_IN);
        SP_IN = sp;
        WAIT_STATE_IN = w;
        repeat (2) @(negedge CLOCK_IN);
        chk("stack extra", 16'(e), 16'(STACK_EXTRA_OUT));
    endtask

    initial begin
        repeat (5) @(negedge CLOCK_IN);
        SRST_IN = 1'b0;
        chk("idle", 16'h0000, {15'h0000, BUSY_OUT});
        t_ptr();
        t_direct();
        t_bits();
        t_pgm();
        t_alu();
        t_stack(16'h025F, 1'b1, 3'h0);
        t_stack(16'h0260, 1'b0, 3'h2);
        t_stack(16'h0260, 1'b1, 3'h4);
        tally_and_finish();
    end
endmodule
